/* File: src/mcp_pkg.sv */
// Shared constants and types of the macrocell configuration and preload block.
// Assumes a single 200 MHz core clock and a programmer-side row port.
package mcp_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int NUM_CELLS = 8;
    localparam int ROW_BITS = 64;
    localparam int ACW_BITS = 82;
    localparam int ADDR_W = 6;
    localparam int ARRAY_ROWS = 40;

    // ************************************************************
    // Row map
    // ************************************************************
    localparam logic [5:0] ROW_ARRAY_LAST = 6'h27;
    localparam logic [5:0] ROW_SIGNATURE = 6'h28;
    localparam logic [5:0] ROW_RSV_FIRST = 6'h29;
    localparam logic [5:0] ROW_RSV_LAST = 6'h3B;
    localparam logic [5:0] ROW_ARCH = 6'h3C;
    localparam logic [5:0] ROW_SECURITY = 6'h3D;
    localparam logic [5:0] ROW_BULK_ERASE = 6'h3F;

    // ************************************************************
    // Architecture word fields
    // ************************************************************
    localparam int ACW_POL_LSB = 0;
    localparam int ACW_CELL_LSB = 8;
    localparam int ACW_GLOBAL_BIT = 16;
    localparam int ACW_REGCAP_BIT = 17;

    // ************************************************************
    // Values after erase and readback filler
    // ************************************************************
    localparam logic [81:0] ACW_ERASED = 82'h0;
    localparam logic [63:0] ROW_ERASED = 64'h0000_0000_0000_0000;
    localparam logic [81:0] RSV_READ_VALUE = 82'h0;

    // ************************************************************
    // Power-up reset delay
    // ************************************************************
    localparam int RESET_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_CYCLES = RESET_DELAY_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MCP_PT_NONE = 2'b00,
        MCP_PT_EIGHT = 2'b01,
        MCP_PT_SEVEN = 2'b11
    } mcp_pt_t;

    typedef enum logic [2:0] {
        MCP_FB_NONE = 3'b000,
        MCP_FB_ADJ = 3'b001,
        MCP_FB_REG = 3'b011,
        MCP_FB_PIN = 3'b010
    } mcp_fb_t;

endpackage

/* File: src/mcp_row_if.sv */
// Row access bundle between the controller and the array memory.
// Assumes one clock; read data returns one cycle after the request.
`timescale 1ns/1ps
interface mcp_row_if;
    logic wr_en;
    logic clr_all;
    logic [5:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;

    modport ctrl (
        output wr_en,
        output clr_all,
        output addr,
        output wdata,
        input rdata
    );
    modport mem (
        input wr_en,
        input clr_all,
        input addr,
        input wdata,
        output rdata
    );
endinterface

/* File: src/mcp_array_mem.sv */
// User array of forty 64-bit rows with registered read data.
// Assumes the caller has already filtered secured and out-of-range rows.
`timescale 1ns/1ps
module mcp_array_mem #(
    parameter int ROWS = mcp_pkg::ARRAY_ROWS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    mcp_row_if.mem row
);
    logic [63:0] mem_q [ROWS];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            row.rdata <= mcp_pkg::ROW_ERASED;
        end else begin
            row.rdata <= mem_q[row.addr];
        end
    end

    // ************************************************************
    // Storage, one word per row
    // ************************************************************
    for (genvar i = 0; i < ROWS; i++) begin : g_row
        always_ff @(posedge core_clk) begin
            if (row.clr_all) begin
                mem_q[i] <= mcp_pkg::ROW_ERASED;
            end else if (row.wr_en && row.addr == 6'(i)) begin
                mem_q[i] <= row.wdata;
            end
        end
    end
endmodule

/* File: src/mcp_cell_decode.sv */
// Decode of one output macrocell from its architecture bits.
// Assumes the top feeds the registered-capability bit as global for edge cells.
`timescale 1ns/1ps
module mcp_cell_decode (
    input wire logic global_bit,
    input wire logic cell_bit,
    input wire logic neighbour_bit,
    input wire logic regcap,
    input wire logic edge_cell,
    output mcp_pkg::mcp_pt_t pt_sel,
    output mcp_pkg::mcp_fb_t fb_sel,
    output logic is_reg,
    output logic oe_common,
    output logic oe_pterm,
    output logic oe_always,
    output logic oe_off
);
    wire logic combo_on = !global_bit && !cell_bit;
    wire logic dis_cell = !global_bit && cell_bit;
    wire logic reg_mode = global_bit && !cell_bit && !regcap && !edge_cell;
    wire logic pt_mode = global_bit && cell_bit;
    // Registered capability set, or an edge cell, with global on and cell off: output dead, no feedback
    wire logic dead = global_bit && !cell_bit && (regcap || edge_cell);

    assign is_reg = reg_mode;                   // [R4]
    assign oe_common = reg_mode;                // [R21]
    assign oe_pterm = pt_mode;                  // [R5]
    assign oe_always = combo_on;                // [R2]
    assign oe_off = dis_cell || dead;           // [R3] [R6]
    assign pt_sel = pt_mode ? mcp_pkg::MCP_PT_SEVEN :
                    (combo_on || reg_mode) ? mcp_pkg::MCP_PT_EIGHT :
                    mcp_pkg::MCP_PT_NONE;
    assign fb_sel = reg_mode ? mcp_pkg::MCP_FB_REG :
                    pt_mode ? mcp_pkg::MCP_FB_PIN :
                    (!global_bit && neighbour_bit) ? mcp_pkg::MCP_FB_ADJ :
                    mcp_pkg::MCP_FB_NONE;  // [R2] [R3] [R6]
endmodule

/* File: src/mcp_top.sv */
// Macrocell configuration, row programming map and register preload.
// Assumes a programmer drives the row port and a tester the preload pins,
// all synchronous to core_clk; sum terms arrive already evaluated.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Each output has its own polarity bit: 0 active low, 1 active high.
// [R2] Both arch bits zero: 8-term combinational output, always on.
// [R3] Global zero, cell one: output high impedance, adjacent or no feedback.
// [R4] Global one, cell zero, no capability: registered 8-term, common enable.
// [R5] Both arch bits one: 7-term combinational, eighth term drives enable.
// [R6] Capability, global one, cell zero: output off, no feedback.
// [R7] Sixty-four row addresses; rows 0-39 hold 64-bit array data.
// [R8] Row 40 holds a 64-bit signature, always readable.
// [R9] Rows 41-59 reserved, neither programmable nor readable.
// [R10] Row 60 holds the 82-bit architecture word.
// [R11] Security set blocks program and readback of rows 0-39.
// [R12] Security clears only through bulk erase with the array; sys_rst also clears it here and leaves the array intact.
// [R13] Row 63 erases array, architecture, signature and security.
// [R14] Preload forces each registered output high or low synchronously.
// [R15] Preload enable opens serial pins; one bit per shift clock rise.
// [R16] Chain holds only registered macrocells.
// [R17] Chain fills from bottom registered macrocell upward.
// [R18] Power-up clears every register within the reset delay.
// [R19] Outside party waits for setup before clocking after power-up.
// [R20] Outermost cells use capability bit instead of global bit.
// [R21] Registered cells use the common output enable pin.
// [R22] Reserved rows ignore writes and read a fixed value.
module mcp_top #(
    parameter int CELLS = mcp_pkg::NUM_CELLS,
    parameter int RESET_CYCLES = mcp_pkg::RESET_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic logic_clk_en,
    input wire logic [CELLS-1:0] sum_eight,
    input wire logic [CELLS-1:0] sum_seven,
    input wire logic [CELLS-1:0] pterm_oe,
    input wire logic common_oe_n,
    input wire logic [CELLS-1:0] pin_in,
    output logic [CELLS-1:0] out_pin,
    output logic [CELLS-1:0] out_oe_n,
    output logic [CELLS-1:0] feedback,
    output logic ready,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [5:0] prog_addr,
    input wire logic [81:0] prog_wdata,
    output logic [81:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_refused,
    output logic secured,
    input wire logic preload_enable_pin,
    input wire logic preload_shift_clock,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n
);
    // ************************************************************
    // Configuration storage
    // ************************************************************
    logic [81:0] acw_q;
    logic [63:0] sig_q;
    logic sec_q;
    logic [CELLS-1:0] reg_q;
    logic [CELLS-1:0] reg_d;
    logic [15:0] rst_cnt_q;
    logic ready_q;
    logic shclk_q;
    logic rd_pend_q;
    logic [5:0] rd_addr_q;
    logic [81:0] rdata_q;
    logic refused_q;

    // All checks in this module sample on the core clock, off in reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    mcp_row_if row ();

    mcp_array_mem u_mem (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .row(row)
    );

    // ************************************************************
    // Row decode
    // ************************************************************
    wire logic is_array = prog_addr <= mcp_pkg::ROW_ARRAY_LAST;        // [R7]
    wire logic is_sig = prog_addr == mcp_pkg::ROW_SIGNATURE;
    wire logic is_arch = prog_addr == mcp_pkg::ROW_ARCH;
    wire logic is_sec = prog_addr == mcp_pkg::ROW_SECURITY;
    wire logic is_erase = prog_addr == mcp_pkg::ROW_BULK_ERASE;
    wire logic array_ok = is_array && !sec_q;                       // [R11]
    wire logic wr_go = prog_wr && ready_q;
    wire logic erase_go = wr_go && is_erase;                        // [R13]
    wire logic rd_go = prog_rd && ready_q && !prog_wr;
    wire logic bad_acc = (wr_go && is_array && sec_q) ||
                         (rd_go && is_array && sec_q);               // [R11]

    assign row.wr_en = wr_go && array_ok;
    assign row.clr_all = erase_go;                                  // [R12]
    assign row.addr = prog_addr;
    assign row.wdata = prog_wdata[63:0];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acw_q <= mcp_pkg::ACW_ERASED;
            sig_q <= mcp_pkg::ROW_ERASED;
            sec_q <= 1'b0;
        end else if (erase_go) begin
            acw_q <= mcp_pkg::ACW_ERASED;                           // [R13]
            sig_q <= mcp_pkg::ROW_ERASED;
            sec_q <= 1'b0;                                          // [R12]
        end else if (wr_go) begin
            // Reserved rows fall through and change nothing  [R9] [R22]
            if (is_arch) begin
                acw_q <= prog_wdata;                                // [R10]
            end
            if (is_sig) begin
                sig_q <= prog_wdata[63:0];                          // [R8]
            end
            if (is_sec && prog_wdata[0]) begin
                sec_q <= 1'b1;                                      // [R11]
            end
        end
    end

    // ************************************************************
    // Readback, two cycles after the request
    // ************************************************************
    wire logic [81:0] sel_rdata =
        (rd_addr_q <= mcp_pkg::ROW_ARRAY_LAST) ? {18'h0_0000, row.rdata} :
        (rd_addr_q == mcp_pkg::ROW_SIGNATURE) ? {18'h0_0000, sig_q} :
        (rd_addr_q == mcp_pkg::ROW_ARCH) ? acw_q :
        (rd_addr_q == mcp_pkg::ROW_SECURITY) ? {81'h0, sec_q} :
        mcp_pkg::RSV_READ_VALUE;                                    // [R22]

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 6'h00;
            refused_q <= 1'b0;
        end else begin
            rd_pend_q <= rd_go && !(is_array && sec_q);             // [R11]
            rd_addr_q <= prog_addr;
            refused_q <= bad_acc;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= mcp_pkg::RSV_READ_VALUE;
        end else if (rd_pend_q) begin
            rdata_q <= sel_rdata;                                   // [R8]
        end
    end

    assign prog_rdata = rdata_q;
    assign prog_refused = refused_q;
    assign secured = sec_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_rvalid <= 1'b0;
        end else begin
            prog_rvalid <= rd_pend_q;
        end
    end

    // ************************************************************
    // Power-up reset delay
    // ************************************************************
    // Registers are held low until the count ends; clocking earlier
    // is the outside party's responsibility.  [R19]
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_q <= 16'h0000;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            rst_cnt_q <= rst_cnt_q + 16'h0001;
            ready_q <= rst_cnt_q == 16'(RESET_CYCLES - 1);
        end
    end
    assign ready = ready_q;

    // ************************************************************
    // Per-cell decode
    // ************************************************************
    wire logic regcap = acw_q[mcp_pkg::ACW_REGCAP_BIT];
    wire logic glob = acw_q[mcp_pkg::ACW_GLOBAL_BIT];
    logic [CELLS-1:0] is_reg;
    logic [CELLS-1:0] oe_common;
    logic [CELLS-1:0] oe_pterm;
    logic [CELLS-1:0] oe_always;
    logic [CELLS-1:0] oe_off;
    logic [CELLS-1:0] in_chain;
    mcp_pkg::mcp_fb_t fb_sel [CELLS];

    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        localparam bit EDGE = (i == 0) || (i == CELLS - 1);
        localparam int NB = (i == 0) ? 1 : i - 1;
        wire logic cbit = acw_q[mcp_pkg::ACW_CELL_LSB + i];
        wire logic nbit = acw_q[mcp_pkg::ACW_CELL_LSB + NB];
        wire logic pol = acw_q[mcp_pkg::ACW_POL_LSB + i];
        wire logic gsel = EDGE ? regcap : glob;                     // [R20]
        wire logic comb_val = oe_pterm[i] ? sum_seven[i] : sum_eight[i];
        // Polarity is applied ahead of the register  [R1]
        wire logic d_pol = pol ? !sum_eight[i] : sum_eight[i];
        wire logic en = oe_always[i] ||
                        (oe_common[i] && !common_oe_n) ||           // [R21]
                        (oe_pterm[i] && pterm_oe[i]);               // [R5]

        mcp_cell_decode u_dec (
            .global_bit(gsel),
            .cell_bit(cbit),
            .neighbour_bit(nbit),
            .regcap(regcap),
            .edge_cell(EDGE),
            .pt_sel(),
            .fb_sel(fb_sel[i]),
            .is_reg(is_reg[i]),
            .oe_common(oe_common[i]),
            .oe_pterm(oe_pterm[i]),
            .oe_always(oe_always[i]),
            .oe_off(oe_off[i])
        );

        // Polarity 1 passes the sum, 0 inverts it; a registered pin shows
        // the inverse of its bit, so a cleared one reads high  [R1] [R18]
        assign out_pin[i] = is_reg[i] ? !reg_q[i]
                                      : (pol ? comb_val : !comb_val);
        assign out_oe_n[i] = !(en && !oe_off[i]);                   // [R3] [R6]
        assign feedback[i] =
            (fb_sel[i] == mcp_pkg::MCP_FB_REG) ? reg_q[i] :
            (fb_sel[i] == mcp_pkg::MCP_FB_PIN) ? pin_in[i] :
            (fb_sel[i] == mcp_pkg::MCP_FB_ADJ) ? pin_in[NB] : 1'b0;
        assign in_chain[i] = is_reg[i];                             // [R16]

        // Chain input: next registered cell below, else the serial pin
        logic below;
        always_comb begin
            below = serial_in;
            for (int k = 0; k < i; k++) begin
                if (in_chain[k]) begin
                    below = reg_q[k];                               // [R17]
                end
            end
        end
        assign reg_d[i] = preload_enable_pin ? below : d_pol;
    end

    // ************************************************************
    // Macrocell registers and preload shift
    // ************************************************************
    wire logic shift_rise = preload_shift_clock && !shclk_q;         // [R15]
    // Lowest registered cell, the one the serial pin feeds
    wire logic [CELLS-1:0] chain_low = in_chain & (-in_chain);
    wire logic [CELLS-1:0] load_en = preload_enable_pin ?
        (shift_rise ? in_chain : '0) :                              // [R14]
        (logic_clk_en ? is_reg : '0);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shclk_q <= 1'b0;
        end else begin
            shclk_q <= preload_shift_clock;
        end
    end

    for (genvar i = 0; i < CELLS; i++) begin : g_reg
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                reg_q[i] <= 1'b0;                                   // [R18]
            end else if (!ready_q) begin
                reg_q[i] <= 1'b0;                                   // [R18]
            end else if (load_en[i]) begin
                reg_q[i] <= reg_d[i];
            end
        end
    end

    // Top registered cell leaves the chain on the serial output
    logic top_bit;
    always_comb begin
        top_bit = serial_in;
        for (int k = 0; k < CELLS; k++) begin
            if (in_chain[k]) begin
                top_bit = reg_q[k];
            end
        end
    end
    assign serial_out = top_bit;
    assign serial_out_oe_n = !preload_enable_pin;                   // [R15]

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_secured_read;
        rd_go && is_array && sec_q;
    endsequence
    sequence s_shift_taken;
        preload_enable_pin && shift_rise && ready_q && |in_chain;
    endsequence

    a_erase_clears: assert property (erase_go |=> !sec_q && // [R13]
        acw_q == mcp_pkg::ACW_ERASED && sig_q == mcp_pkg::ROW_ERASED)
        else $error("Bulk erase left state behind");
    a_secure_refuse: assert property (s_secured_read |=> // [R11]
        prog_refused ##1 !prog_rvalid)
        else $error("Secured array row was read back");
    a_refuse_write: assert property (wr_go && is_array && sec_q |-> // [R11]
        !row.wr_en ##1 prog_refused)
        else $error("Secured array row accepted a write");
    a_sec_sticky: assert property ($fell(sec_q) |-> $past(erase_go)) // [R12]
        else $error("Security cleared without bulk erase");

    a_rsv_nowrite: assert property (wr_go && // [R22]
        prog_addr >= mcp_pkg::ROW_RSV_FIRST &&
        prog_addr <= mcp_pkg::ROW_RSV_LAST |=> $stable({acw_q, sig_q, sec_q}))
        else $error("Reserved row changed configuration");
    a_sig_read: assert property (rd_go && is_sig |-> ##2 ( // [R8]
        prog_rvalid && prog_rdata[63:0] == sig_q))
        else $error("Signature not readable");

    a_reset_low: assert property (!ready_q |=> reg_q == '0) // [R18]
        else $error("Register not cleared during reset delay");
    a_reg_pin_inv: assert property (&(out_pin | ~is_reg | reg_q)) // [R18]
        else $error("Cleared register does not show high");

    a_arch_store: assert property (wr_go && is_arch |=> // [R10]
        acw_q == $past(prog_wdata))
        else $error("Architecture word not stored");
    a_shift_hold: assert property (preload_enable_pin && // [R15]
        !shift_rise && ready_q |=> $stable(reg_q))
        else $error("Preload chain moved without a shift edge");
    a_chain_only: assert property (s_shift_taken |=> // [R16]
        ((reg_q ^ $past(reg_q)) & ~$past(in_chain)) == '0)
        else $error("Cell outside the chain was shifted");
    a_bottom_fill: assert property (s_shift_taken |=> // [R17]
        |(reg_q & $past(chain_low)) == $past(serial_in))
        else $error("Bottom registered cell missed the serial bit");
endmodule

/* File: verif/mcp_tester.sv */
// Tester model that drives the preload pins of the device.
// Assumes the bench calls load() and that core_clk is shared.
`timescale 1ns/1ps
module mcp_tester (
    input wire logic core_clk,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    output logic preload_enable_pin,
    output logic preload_shift_clock,
    output logic serial_in,
    output logic sdo_seen,
    output logic sdo_oe_seen
);
    initial begin
        preload_enable_pin = 1'b0;
        preload_shift_clock = 1'b0;
        serial_in = 1'b1;
        sdo_seen = 1'b0;
        sdo_oe_seen = 1'b1;
    end
    // Shift clock rests low outside a load; n equals registered cells
    task automatic load(input logic [7:0] bits, input int n);
        @(negedge core_clk);
        preload_enable_pin = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            serial_in = bits[i];
            @(negedge core_clk);
            preload_shift_clock = 1'b1; // One bit per rise
            @(negedge core_clk);
            preload_shift_clock = 1'b0;
        end
        @(negedge core_clk);
        sdo_seen = serial_out;
        sdo_oe_seen = serial_out_oe_n;
        preload_enable_pin = 1'b0;
        // Released line must not keep showing the last bit
        serial_in = ~serial_in;
    endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the macrocell configuration block.
// Assumes a 200 MHz core clock and the tester model on the preload pins.
`timescale 1ns/1ps
module tb;
    logic core_clk, sys_rst, logic_clk_en, common_oe_n, ready;
    logic [7:0] sum_eight, sum_seven, pterm_oe, pin_in, out_pin, out_oe_n, fb;
    logic prog_wr, prog_rd, prog_rvalid, prog_refused, secured, gotv, gotr;
    logic [5:0] prog_addr;
    logic [81:0] prog_wdata, prog_rdata, got;
    logic pe, psc, sdi, sdo, sdo_oe_n, seen, oe_seen;
    logic [2:0] md [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b110};
    logic oex [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic fbx [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int err_count, checked;
    localparam logic [81:0] SIG = 82'h1234_5678_9ABC_DEF0;
    localparam logic [81:0] ROWD = 82'hA5A5_0F0F_3C3C_9696;

    mcp_top #(.CELLS(8), .RESET_CYCLES(4)) mcp_top_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .logic_clk_en(logic_clk_en),
        .sum_eight(sum_eight), .sum_seven(sum_seven), .pterm_oe(pterm_oe),
        .common_oe_n(common_oe_n), .pin_in(pin_in), .out_pin(out_pin),
        .out_oe_n(out_oe_n), .feedback(fb), .ready(ready), .prog_wr(prog_wr),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
        .prog_refused(prog_refused), .secured(secured),
        .preload_enable_pin(pe), .preload_shift_clock(psc),
        .serial_in(sdi), .serial_out(sdo), .serial_out_oe_n(sdo_oe_n));
    mcp_tester mcp_tester_inst (
        .core_clk(core_clk), .serial_out(sdo), .serial_out_oe_n(sdo_oe_n),
        .preload_enable_pin(pe), .preload_shift_clock(psc),
        .serial_in(sdi), .sdo_seen(seen), .sdo_oe_seen(oe_seen));

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk(input logic [81:0] g, input logic [81:0] e,
                       input string m);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [81:0] d);
        @(negedge core_clk);
        prog_wr = 1'b1;
        prog_addr = a;
        prog_wdata = d;
        @(negedge core_clk);
        prog_wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge core_clk);
        prog_rd = 1'b1;
        prog_addr = a;
        @(negedge core_clk);
        prog_rd = 1'b0;
        gotv = 1'b0;
        gotr = (prog_refused === 1'b1);
        repeat (3) begin
            @(negedge core_clk);
            gotv = gotv | (prog_rvalid === 1'b1);
            gotr = gotr | (prog_refused === 1'b1);
            if (prog_rvalid === 1'b1) got = prog_rdata;
        end
    endtask
    task automatic rc(input logic [5:0] a, input logic [81:0] e);
        rd(a);
        chk(gotv, 1'b1, "no read answer");
        chk(got, e, "read data");
    endtask
    task automatic clk_en(input logic [7:0] s);
        sum_eight = s;
        @(negedge core_clk);
        logic_clk_en = 1'b1;
        @(negedge core_clk);
        logic_clk_en = 1'b0;
    endtask
    task automatic rst_wait;
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(ready, 1'b0, "ready early");
        for (int i = 0; i < 50 && ready !== 1'b1; i++) @(negedge core_clk);
        chk(ready, 1'b1, "ready never rose");
    endtask
    function automatic logic [81:0] acw(input logic r, input logic g,
                                        input logic [7:0] c,
                                        input logic [7:0] p);
        return {64'h0, r, g, c, p};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        err_count = 0;
        checked = 0;
        {logic_clk_en, prog_wr, prog_rd, common_oe_n} = 4'h0;
        {sum_eight, sum_seven, pterm_oe, pin_in} = 32'hFF00_005A;
        prog_addr = 6'h00;
        prog_wdata = 82'h0;
        rst_wait();
        rc(6'h3C, 82'h0);
        wr(6'h28, SIG);
        wr(6'h05, ROWD);
        rc(6'h28, SIG);
        rc(6'h05, ROWD);
        wr(6'h2D, ROWD);
        wr(6'h3E, ROWD);
        rc(6'h2D, 82'h0);
        rc(6'h3E, 82'h0);
        rc(6'h3C, 82'h0);
        $display("test rows done");
        common_oe_n = 1'b1;
        pterm_oe = 8'hFF;
        for (int i = 0; i < 5; i++) begin
            wr(6'h3C, acw(md[i][2], md[i][1], {8{md[i][0]}}, 8'hFF));
            chk(out_oe_n[3], oex[i], "cell enable");
            chk(fb[4], fbx[i], "feedback");
        end
        wr(6'h3C, acw(1'b0, 1'b0, 8'h00, 8'hF7));
        chk(out_pin[4:3], 2'b10, "polarity");
        wr(6'h3C, acw(1'b0, 1'b1, 8'h00, 8'hFF));
        chk(out_oe_n[0], 1'b0, "edge cell decode");
        chk(out_oe_n[3], 1'b1, "common enable off");
        common_oe_n = 1'b0;
        clk_en(8'h08);
        chk({out_oe_n[3], out_pin[3]}, 2'b01, "registered high");
        clk_en(8'h00);
        chk(out_pin[3], 1'b0, "registered low");
        wr(6'h3C, acw(1'b0, 1'b1, 8'hFF, 8'hFF));
        sum_seven = 8'h08;
        pterm_oe = 8'hF7;
        @(negedge core_clk);
        chk({out_oe_n[3], out_pin[3]}, 2'b11, "term enable");
        $display("test decode done");
        wr(6'h3C, acw(1'b0, 1'b1, 8'hD5, 8'hFF));
        mcp_tester_inst.load(8'h01, 3);
        chk(out_pin & 8'h2A, 8'h0A, "chain");
        chk({seen, oe_seen}, 2'b10, "serial out");
        rst_wait();
        wr(6'h3C, acw(1'b0, 1'b1, 8'hD5, 8'hFF));
        chk(out_pin[5], 1'b1, "reset register");
        $display("test preload done");
        wr(6'h28, SIG);
        wr(6'h05, ROWD);
        wr(6'h3D, 82'h1);
        chk(secured, 1'b1, "security set");
        rd(6'h05);
        chk({gotr, gotv}, 2'b10, "secured read");
        wr(6'h05, 82'h0);
        rc(6'h28, SIG);
        wr(6'h3F, 82'h0);
        chk(secured, 1'b0, "erase security");
        rc(6'h05, 82'h0);
        rc(6'h28, 82'h0);
        rc(6'h3C, 82'h0);
        $display("test security done");
        report_and_stop();
    end
endmodule
